// ### core/tsw_regs.svh
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH

// register indices; byte address is four times the index
`define TSW_IDX_LINK_HEALTH   10'h133
`define TSW_IDX_WAKE_CFG      10'h17F
`define TSW_IDX_TIMER_SEL     10'h180
`define TSW_IDX_RX_SLEEP_CNT  10'h181
`define TSW_IDX_WAKE_CNT      10'h182
`define TSW_IDX_OVERRIDE      10'h183
`define TSW_IDX_ABORT         10'h1B

// reset values
`define TSW_RST_WAKE_CFG      16'h4028
`define TSW_RST_ZERO          16'h0000

// link health fields
`define TSW_B_CS_UP           14
`define TSW_B_SEND_DATA       13
`define TSW_B_LINK            12
`define TSW_B_DESCR           2
`define TSW_B_LOC_RX          1
`define TSW_B_REM_RX          0

// wake config fields
`define TSW_B_WUR_EN          15
`define TSW_B_WUP_EN          14
`define TSW_WAKE_CFG_MASK     16'hC0FF

// timer select fields
`define TSW_REQ_HI            4
`define TSW_REQ_LO            3
`define TSW_ACK_HI            1
`define TSW_ACK_LO            0
`define TSW_TIMER_MASK        16'h001B

// sleep timer choices in milliseconds, selector codes 0 to 3
`define TSW_REQ_MS_0          16
`define TSW_REQ_MS_1          4
`define TSW_REQ_MS_2          32
`define TSW_REQ_MS_3          40
`define TSW_ACK_MS_0          8
`define TSW_ACK_MS_1          6
`define TSW_ACK_MS_2          24
`define TSW_ACK_MS_3          32

// override fields
`define TSW_B_SEND_WUP        15
`define TSW_B_SLEEP_EN        14
`define TSW_B_SLEEP_VAL       13
`define TSW_B_TXLPS_EN        12
`define TSW_B_TXLPS_VAL       11
`define TSW_B_LCTL_EN         10
`define TSW_B_LCTL_VAL        9
`define TSW_B_ST_EN           8
`define TSW_OVR_MASK          16'hFF7F
`define TSW_CNT_MASK          16'h03FF
`define TSW_B_ABORT           0

// timing
`define TSW_CLK_MHZ           10
`define TSW_CYC_PER_US        (`TSW_CLK_MHZ)
`define TSW_CYC_PER_MS        (`TSW_CLK_MHZ * 1000)
`define TSW_US_W              8

`endif

// ### core/tsw_pkg.sv
package tsw_pkg;
  typedef enum logic [2:0] {
    TSW_IDLE, TSW_REQ, TSW_ACK, TSW_SLEEP
  } tsw_sleep_st_t;
endpackage : tsw_pkg

// ### core/tsw_sync.sv
`timescale 1ns/1ps
module tsw_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage is read by the second stage only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : tsw_sync

// ### core/tsw_sleep_wake_regs.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "tsw_regs.svh"

// Notes on behaviour
// - bit 12 shows link monitor state
// - bit 13 set while in send data
// - bit 14 shows link up, resets zero
// - bit 2 shows descrambler lock
// - bit 1 shows local receiver valid
// - bit 0 shows remote receiver valid
// - wake enable sends wur on active link
// - wake pulse must reach microsecond threshold
// - wup after pin wake when enabled
// - sleep request time from bits 4-3
// - sleep acknowledge time from bits 1-0
// - ten bit received sleep code counter
// - ten bit received wake code counter
// - write one sends wup in disable transmit
// - sleep signal override from bit 13
// - transmit sleep request override from bit 11
// - link control override from bit 9
// - hold sleep fsm in forced state for codes 0 to 3; other codes only show on sleep_fsm_state
// - abort bit aborts sleep in acknowledge
module tsw_sleep_wake_regs
  import tsw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins and phy status
  input  wire logic        wake_pin,
  input  wire logic        link_mon_up,
  input  wire logic        link_up_cs,
  input  wire logic        phy_ctrl_send_data,
  input  wire logic        phy_ctrl_dis_tx,
  input  wire logic        descr_locked,
  input  wire logic        loc_rx_ok,
  input  wire logic        rem_rx_ok,
  // sleep and wake code events, local sleep request and link control level
  input  wire logic        rx_sleep_code,
  input  wire logic        rx_wake_code,
  input  wire logic        sleep_req_local,
  input  wire logic        link_ctrl_in,
  // towards phy control
  output logic             send_wur,
  output logic             send_wup,
  output logic             sleep_to_phy,
  output logic             tx_sleep_req,
  output logic             link_ctrl_out,
  output logic      [6:0]  sleep_fsm_state
);

  typedef struct packed {
    logic [31:0]   dat;
    logic          ack;
    logic [15:0]   wake_cfg;
    logic [15:0]   timer_sel;
    logic [15:0]   ovr;
    logic          abort;
    logic [9:0]    rx_sleep_cnt;
    logic [9:0]    rx_wake_cnt;
    logic [15:0]   status;
    logic [7:0]    us_div;
    logic [7:0]    width_us;
    logic          wake_prev;
    logic          sent_wur;
    logic          slept;
    logic          wur;
    logic          wup;
    logic          sleep_o;
    logic          txlps_o;
    logic          lctl_o;
    logic [6:0]    st_o;
    tsw_sleep_st_t st;
    logic [18:0]   tmr;
  } tsw_state_t;

  tsw_state_t s_q;
  tsw_state_t s_d;

  logic [10:0] in_raw;
  logic [10:0] in_s;
  logic        access;
  logic        wr;
  logic [9:0]  idx;
  logic [15:0] wd;
  logic [15:0] rd;
  logic [18:0] req_cyc;
  logic [18:0] ack_cyc;
  logic        w_wake;
  logic        w_link;
  logic        w_dis_tx;

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  assign in_raw = {wake_pin, link_mon_up, link_up_cs, phy_ctrl_send_data,
                   phy_ctrl_dis_tx, descr_locked, loc_rx_ok, rem_rx_ok,
                   rx_sleep_code, rx_wake_code, link_ctrl_in};

  tsw_sync #(.W(11)) u_sync
  (
    .clk (clk),
    .rst (rst),
    .d   (in_raw),
    .q   (in_s)
  );

  assign w_wake   = in_s[10];
  assign w_link   = in_s[9];
  assign w_dis_tx = in_s[6];

  // -------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------
  assign access = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr     = access && wb_we_i;
  assign idx    = wb_adr_i[11:2];
  assign wd     = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                   wb_dat_i[7:0]};

  always_comb
  begin
    unique case (idx)
      `TSW_IDX_LINK_HEALTH:  rd = s_q.status;
      `TSW_IDX_WAKE_CFG:     rd = s_q.wake_cfg;
      `TSW_IDX_TIMER_SEL:    rd = s_q.timer_sel;
      `TSW_IDX_RX_SLEEP_CNT: rd = {6'h00, s_q.rx_sleep_cnt};
      `TSW_IDX_WAKE_CNT:     rd = {6'h00, s_q.rx_wake_cnt};
      `TSW_IDX_OVERRIDE:     rd = s_q.ovr;
      `TSW_IDX_ABORT:        rd = {15'h0000, s_q.abort};
      default:               rd = `TSW_RST_ZERO;
    endcase
  end

  // -------------------------------------------------------------
  // sleep timers
  // -------------------------------------------------------------
  // request time
  always_comb
  begin
    unique case (s_q.timer_sel[`TSW_REQ_HI:`TSW_REQ_LO])
      2'h0: req_cyc = 19'(`TSW_REQ_MS_0 * `TSW_CYC_PER_MS);
      2'h1: req_cyc = 19'(`TSW_REQ_MS_1 * `TSW_CYC_PER_MS);
      2'h2: req_cyc = 19'(`TSW_REQ_MS_2 * `TSW_CYC_PER_MS);
      2'h3: req_cyc = 19'(`TSW_REQ_MS_3 * `TSW_CYC_PER_MS);
    endcase
  end

  always_comb
  begin
    unique case (s_q.timer_sel[`TSW_ACK_HI:`TSW_ACK_LO])
      2'h0: ack_cyc = 19'(`TSW_ACK_MS_0 * `TSW_CYC_PER_MS);
      2'h1: ack_cyc = 19'(`TSW_ACK_MS_1 * `TSW_CYC_PER_MS);
      2'h2: ack_cyc = 19'(`TSW_ACK_MS_2 * `TSW_CYC_PER_MS);
      2'h3: ack_cyc = 19'(`TSW_ACK_MS_3 * `TSW_CYC_PER_MS);
    endcase
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    s_d     = s_q;
    s_d.ack = access;
    s_d.wur = 1'b0;
    s_d.wup = 1'b0;
    if (access)
      s_d.dat = {16'h0000, rd};
    // registers written only with the low lane selected
    if (wr && wb_sel_i[0])
    begin
      unique case (idx)
        `TSW_IDX_WAKE_CFG:
          s_d.wake_cfg = wd & `TSW_WAKE_CFG_MASK;
        `TSW_IDX_TIMER_SEL:
          s_d.timer_sel = wd & `TSW_TIMER_MASK;
        `TSW_IDX_OVERRIDE:
          s_d.ovr = wd & `TSW_OVR_MASK;
        `TSW_IDX_ABORT:
          s_d.abort = wd[`TSW_B_ABORT];
        default:
          s_d.abort = s_q.abort;
      endcase
    end

    if (wr && wb_sel_i[1] && idx == `TSW_IDX_OVERRIDE
        && wd[`TSW_B_SEND_WUP] && w_dis_tx)
      s_d.wup = 1'b1;

    // status snapshot, refreshed every cycle
    s_d.status = `TSW_RST_ZERO;
    // link up for c and s
    s_d.status[`TSW_B_CS_UP] = in_s[8];
    s_d.status[`TSW_B_SEND_DATA] = in_s[7];
    s_d.status[`TSW_B_LINK] = w_link;
    s_d.status[`TSW_B_DESCR] = in_s[5];
    s_d.status[`TSW_B_LOC_RX] = in_s[4];
    s_d.status[`TSW_B_REM_RX] = in_s[3];

    s_d.wake_prev = w_wake;
    if (in_s[2])
      s_d.rx_sleep_cnt = s_q.rx_sleep_cnt + 10'h001;
    if (in_s[1])
      s_d.rx_wake_cnt = s_q.rx_wake_cnt + 10'h001;

    // microsecond tick measures wake pulse width
    if (!w_wake)
    begin
      s_d.us_div   = 8'h00;
      s_d.width_us = 8'h00;
      s_d.sent_wur = 1'b0;
    end
    else if (s_q.us_div == 8'(`TSW_CYC_PER_US - 1))
    begin
      s_d.us_div = 8'h00;
      if (s_q.width_us != 8'hFF)
        s_d.width_us = s_q.width_us + 8'h01;
    end
    else
      s_d.us_div = s_q.us_div + 8'h01;

    if (w_wake && w_link && !s_q.sent_wur
        && s_q.wake_cfg[`TSW_B_WUR_EN]
        && s_q.width_us >= s_q.wake_cfg[`TSW_US_W-1:0])
    begin
      s_d.wur      = 1'b1;
      s_d.sent_wur = 1'b1;
    end

    // wup after pin wake from sleep
    if (s_q.st == TSW_SLEEP && w_wake && !s_q.wake_prev)
    begin
      s_d.slept = 1'b0;
      s_d.st    = TSW_IDLE;
      if (s_q.wake_cfg[`TSW_B_WUP_EN])
        s_d.wup = 1'b1;
    end

    // sleep fsm
    if (s_q.tmr != 19'h00000)
      s_d.tmr = s_q.tmr - 19'h00001;
    unique case (s_q.st)
      TSW_IDLE:
        if (sleep_req_local && w_link)
        begin
          s_d.st  = TSW_REQ;
          s_d.tmr = req_cyc;
        end
      TSW_REQ:
        if (s_q.tmr == 19'h00000)
        begin
          s_d.st  = TSW_ACK;
          s_d.tmr = ack_cyc;
        end
      TSW_ACK:
        if (s_q.abort)
          s_d.st = TSW_IDLE;
        else if (s_q.tmr == 19'h00000)
        begin
          s_d.st    = TSW_SLEEP;
          s_d.slept = 1'b1;
        end
      TSW_SLEEP:
        s_d.slept = 1'b1;
    endcase

    // a legal forced code steers the machine itself
    if (s_q.ovr[`TSW_B_ST_EN] && s_q.ovr[6:2] == 5'h00)
      s_d.st = tsw_sleep_st_t'({1'b0, s_q.ovr[1:0]});

    s_d.sleep_o = s_q.ovr[`TSW_B_SLEEP_EN] ? s_q.ovr[`TSW_B_SLEEP_VAL]
                                           : (s_d.st == TSW_SLEEP);
    s_d.txlps_o = s_q.ovr[`TSW_B_TXLPS_EN] ? s_q.ovr[`TSW_B_TXLPS_VAL]
                                           : (s_d.st == TSW_REQ);
    s_d.lctl_o = s_q.ovr[`TSW_B_LCTL_EN] ? s_q.ovr[`TSW_B_LCTL_VAL]
                                         : in_s[0];
    s_d.st_o = s_q.ovr[`TSW_B_ST_EN] ? s_q.ovr[6:0]
                                     : {4'h0, s_d.st};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.wake_cfg <= `TSW_RST_WAKE_CFG;
      s_q.st       <= TSW_IDLE;
    end
    else
      s_q <= s_d;
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign wb_dat_o        = s_q.dat;
  assign wb_ack_o        = s_q.ack;
  assign send_wur        = s_q.wur;
  assign send_wup        = s_q.wup;
  assign sleep_to_phy    = s_q.sleep_o;
  assign tx_sleep_req    = s_q.txlps_o;
  assign link_ctrl_out   = s_q.lctl_o;
  assign sleep_fsm_state = s_q.st_o;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_ack_single: assert property
    (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  chk_link_status: assert property
    ($rose(w_link) |=> s_q.status[`TSW_B_LINK])
    else $error("link bit not set");
  chk_wur_disabled: assert property
    (!s_q.wake_cfg[`TSW_B_WUR_EN] |=> !send_wur)
    else $error("wur while disabled");
  chk_wur_width: assert property
    ($rose(send_wur) |-> $past(s_q.width_us) >= $past(s_q.wake_cfg[7:0]))
    else $error("wur pulse too short");
  chk_sleep_ovr: assert property
    (s_q.ovr[`TSW_B_SLEEP_EN] |=> sleep_to_phy == $past(s_q.ovr[13]))
    else $error("sleep override ignored");
  chk_txlps_ovr: assert property
    (s_q.ovr[`TSW_B_TXLPS_EN] |=> tx_sleep_req == $past(s_q.ovr[11]))
    else $error("tx sleep override ignored");
  chk_lctl_pass: assert property
    (!s_q.ovr[`TSW_B_LCTL_EN] |=> link_ctrl_out == $past(in_s[0]))
    else $error("link control not passed");
  chk_abort_ack: assert property
    (s_q.st == TSW_ACK && s_q.abort |=> s_q.st == TSW_IDLE)
    else $error("abort ignored");
  chk_state_ovr: assert property
    (s_q.ovr[`TSW_B_ST_EN] |=> sleep_fsm_state == $past(s_q.ovr[6:0]))
    else $error("state override ignored");

  cov_wur: cover property (send_wur);
  cov_wup: cover property (send_wup);
  cov_sleep: cover property (s_q.st == TSW_SLEEP);
  cov_write: cover property (wb_ack_o && wb_we_i);
endmodule : tsw_sleep_wake_regs

// ### verif/tsw_phy_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// remote phy and phy control levels
// ------------------------------------------
module tsw_phy_model
(
  // clock
  input  wire logic clk,
  // levels towards the register bank
  output logic      link_ctrl_in,
  output logic      phy_ctrl_dis_tx,
  output logic      link_up_cs,
  output logic      phy_ctrl_send_data,
  output logic      link_mon_up,
  output logic      descr_locked,
  output logic      loc_rx_ok,
  output logic      rem_rx_ok,
  // received code events
  output logic      rx_sleep_code,
  output logic      rx_wake_code
);
  logic [7:0] st_q = 8'h00;
  logic       lps_q = 1'b0;
  logic       wur_q = 1'b0;

  assign {link_ctrl_in, phy_ctrl_dis_tx, link_up_cs, phy_ctrl_send_data,
          link_mon_up, descr_locked, loc_rx_ok, rem_rx_ok} = st_q;
  assign rx_sleep_code = lps_q;
  assign rx_wake_code  = wur_q;

  task automatic set_st(input logic [7:0] v);
    @(posedge clk);
    st_q <= v;
  endtask : set_st

  // one cycle per code with a gap, so the synced copy counts once
  task automatic codes(input int nl, input int nw);
    for (int i = 0; i < nl + nw; i++)
    begin
      @(posedge clk);
      lps_q <= (i < nl);
      wur_q <= (i >= nl);
      @(posedge clk);
      lps_q <= 1'b0;
      wur_q <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : codes
endmodule : tsw_phy_model

// ### verif/tsw_sleep_wake_regs_bench.sv
`timescale 1ns/1ps
`include "tsw_regs.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tsw_sleep_wake_regs_bench;
  logic        clk;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_o;
  logic        ack;
  logic        wake = 1'b0;
  logic        req = 1'b0;
  logic        lci, dtx, cs, sd, lm, dl, lo, ro, rl, rw;
  logic        wur, wup, slp, txl, lco;
  logic [6:0]  st;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          nwur = 0;
  int          nwup = 0;
  logic [15:0] r;
  logic [9:0]  ri [6] = '{10'h133, 10'h17F, 10'h180, 10'h181, 10'h182,
                          10'h183};
  logic [15:0] rv [6] = '{16'h0000, 16'h4028, 16'h0000, 16'h0000,
                          16'h0000, 16'h0000};
  logic [15:0] mk [6] = '{16'h0000, 16'hC0FF, 16'h001B, 16'h0000,
                          16'h0000, 16'hFF7F};

  tsw_sleep_wake_regs tsw_sleep_wake_regs_inst (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wake_pin(wake), .link_mon_up(lm), .link_up_cs(cs),
    .phy_ctrl_send_data(sd), .phy_ctrl_dis_tx(dtx), .descr_locked(dl),
    .loc_rx_ok(lo), .rem_rx_ok(ro), .rx_sleep_code(rl),
    .rx_wake_code(rw), .sleep_req_local(req), .link_ctrl_in(lci),
    .send_wur(wur), .send_wup(wup), .sleep_to_phy(slp),
    .tx_sleep_req(txl), .link_ctrl_out(lco), .sleep_fsm_state(st));

  tsw_phy_model tsw_phy_model_inst (.clk(clk), .link_ctrl_in(lci),
    .phy_ctrl_dis_tx(dtx), .link_up_cs(cs), .phy_ctrl_send_data(sd),
    .link_mon_up(lm), .descr_locked(dl), .loc_rx_ok(lo),
    .rem_rx_ok(ro), .rx_sleep_code(rl), .rx_wake_code(rw));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (wur === 1'b1) nwur++;
    if (wup === 1'b1) nwup++;
  end

  // ------------------------------------------
  // bus, state wait and wake pulse tasks
  // ------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic wb(input logic w, input logic [9:0] ix,
                    input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {ix, 2'b00};
    dat <= {d, d};
    sel <= s;
    // ack is looked at only on the sampling edge
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      mismatches++;
      final_report();
    end
    r = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd(input logic [9:0] ix, input logic [15:0] e,
                    input string nm);
    wb(1'b0, ix, 16'h0000, 4'h0);
    `CHK(nm, e, r)
  endtask : rd

  task automatic wait_st(input logic [6:0] v);
    int n;
    n = 0;
    while (st !== v && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("fsm state", v, st)
    if (n >= 2000) final_report();
  endtask : wait_st

  task automatic pulse(input int w);
    @(posedge clk);
    wake <= 1'b1;
    repeat (w) @(posedge clk);
    wake <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : pulse

  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ri[i], rv[i], "reset");
    rd(10'h0AA, 16'h0000, "unmapped");
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, ri[i], 16'hFFFF, 4'hF);
      rd(ri[i], mk[i], "mask");
    end
    wb(1'b1, 10'h183, 16'h0000, 4'hF);
    wb(1'b1, 10'h17F, 16'h0000, 4'hE);
    rd(10'h17F, 16'hC0FF, "lane0 off");
    wb(1'b1, 10'h17F, 16'hC0FF, 4'h1);
    rd(10'h17F, 16'h00FF, "lane1 off");
    tsw_phy_model_inst.set_st(8'h2A);
    repeat (5) @(posedge clk);
    rd(10'h133, 16'h5002, "status a");
    tsw_phy_model_inst.set_st(8'h15);
    repeat (5) @(posedge clk);
    rd(10'h133, 16'h2005, "status b");
    tsw_phy_model_inst.codes(3, 2);
    rd(10'h181, 16'h0003, "sleep codes");
    rd(10'h182, 16'h0002, "wake codes");
    // threshold of 5 us is 50 cycles
    tsw_phy_model_inst.set_st(8'h3F);
    wb(1'b1, 10'h17F, 16'h8005, 4'hF);
    nwur = 0;
    pulse(30);
    `CHK("short pulse", 0, nwur)
    pulse(80);
    `CHK("long pulse", 1, nwur)
    wb(1'b1, 10'h17F, 16'h0005, 4'hF);
    pulse(80);
    `CHK("wur off", 1, nwur)
    nwup = 0;
    wb(1'b1, 10'h183, 16'h8000, 4'hF);
    repeat (5) @(posedge clk);
    `CHK("wup no dis", 0, nwup)
    tsw_phy_model_inst.set_st(8'h7F);
    repeat (5) @(posedge clk);
    wb(1'b1, 10'h183, 16'h8000, 4'hF);
    repeat (5) @(posedge clk);
    `CHK("wup dis", 1, nwup)
    tsw_phy_model_inst.set_st(8'h3F);
    wb(1'b1, 10'h183, 16'h0000, 4'hF);
    // request 4 ms is 40000 cycles; the long timers stay unexercised
    wb(1'b1, 10'h180, 16'h0009, 4'hF);
    @(posedge clk);
    req <= 1'b1;
    wait_st(7'h01);
    repeat (39990) @(posedge clk);
    `CHK("req phase", 7'h01, st)
    wait_st(7'h02);
    // drop the request first, or idle restarts negotiation at once
    @(posedge clk);
    req <= 1'b0;
    wb(1'b1, `TSW_IDX_ABORT, 16'h0001, 4'hF);
    wait_st(7'h00);
    wb(1'b1, `TSW_IDX_ABORT, 16'h0000, 4'hF);
    tsw_phy_model_inst.set_st(8'hBF);
    wb(1'b1, 10'h183, 16'h2A55, 4'hF);
    repeat (5) @(posedge clk);
    `CHK("sleep pass", 1'b0, slp)
    `CHK("txlps pass", 1'b0, txl)
    `CHK("lctl pass", 1'b1, lco)
    `CHK("state pass", 7'h00, st)
    wb(1'b1, 10'h183, 16'h7D55, 4'hF);
    repeat (5) @(posedge clk);
    `CHK("sleep force", 1'b1, slp)
    `CHK("txlps force", 1'b1, txl)
    `CHK("lctl force", 1'b0, lco)
    `CHK("state force", 7'h55, st)
    // force sleep, release the override, then wake by pin
    nwup = 0;
    wb(1'b1, 10'h183, 16'h0103, 4'hF);
    wb(1'b1, 10'h183, 16'h0000, 4'hF);
    repeat (3) @(posedge clk);
    `CHK("asleep", 1'b1, slp)
    `CHK("sleep state", 7'h03, st)
    pulse(5);
    `CHK("woken", 7'h00, st)
    `CHK("wup off", 0, nwup)
    wb(1'b1, 10'h17F, 16'h4005, 4'hF);
    wb(1'b1, 10'h183, 16'h0103, 4'hF);
    wb(1'b1, 10'h183, 16'h0000, 4'hF);
    pulse(5);
    `CHK("wup on", 1, nwup)
    final_report();
  end
endmodule : tsw_sleep_wake_regs_bench
